// *** hw/thermal_inv_defines.svh ***
// constants for the thermal shutdown, inventory and transceiver temperature handler
// assumes the includer wants plain `define macros, no process logic here
`ifndef THERMAL_INV_DEFINES_SVH
`define THERMAL_INV_DEFINES_SVH

// request and response opcodes
`define OPC_THERMAL_CTL      8'h4b
`define OPC_THERMAL_RSP      8'hcb
`define OPC_INVENTORY        8'h4e
`define OPC_INVENTORY_RSP    8'hce
`define OPC_XCVR_TEMP        8'h4a
`define OPC_XCVR_TEMP_RSP    8'hca
`define PKG_CHANNEL_ID       5'h1f

// control action codes
`define ACT_DISABLE          8'h00
`define ACT_ENABLE           8'h01
`define ACT_QUERY            8'h02

// capability and status bit positions
`define CAP_THERMAL_BIT      7
`define STAT_OPER_BIT        0
`define STAT_CFG_BIT         1
`define THERMAL_EN_RESET     1'b1

// response and reason codes
`define RESP_COMPLETED       16'h0000
`define RESP_FAILED          16'h0001
`define REASON_NONE          16'h0000
`define REASON_INVALID_PARAM 16'h0002
`define REASON_INFO_NA       16'h0008

// inventory record types and sizes
`define INV_TYPE_PRODUCT     8'h00
`define INV_TYPE_SERIAL      8'h01
`define INV_NUM_RECORDS      8'h02
`define INV_MAX_LEN          16
`define INV_BYTES            40
`define INV_WORDS            10
`define RESP_WORDS           11

`endif

// *** hw/thermal_inv_pkg.sv ***
// types shared by the thermal shutdown, inventory and transceiver temperature handler
// assumes thermal_inv_defines.svh supplies the widths
`include "thermal_inv_defines.svh"

package thermal_inv_pkg;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [4:0]  channel;
      logic [31:0] action_word;
   } req_t;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [31:0] data;
      logic        last;
   } resp_t;

   typedef struct packed {
      logic        present;
      logic        powered;
      logic        temp_valid;
      logic [15:0] high_alarm;
      logic [15:0] high_warning;
      logic [15:0] temperature;
   } xcvr_t;

   typedef logic [`INV_MAX_LEN-1:0][7:0] inv_text_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } state_t;

endpackage : thermal_inv_pkg

// *** hw/thermal_setting.sv ***
// thermal self-shutdown setting and its control action decode
// assumes apply is a one-cycle pulse per accepted control request
`timescale 1ns/1ps
`include "thermal_inv_defines.svh"

module thermal_setting
(
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst_n,
   // control request
   input  wire logic       apply,
   input  wire logic [7:0] action,
   input  wire logic       cfg_locked,
   // result
   output logic            enabled,
   output logic            next_enabled,
   output logic            fail
);

   logic is_set;
   logic reserved_act;

   assign is_set       = (action == `ACT_DISABLE) || (action == `ACT_ENABLE);
   assign reserved_act = !is_set && (action != `ACT_QUERY);
   // locked setting refuses enable and disable alike
   assign fail         = reserved_act || (is_set && cfg_locked);
   // state reported is the state after the action
   assign next_enabled = (is_set && !fail) ? (action == `ACT_ENABLE) : enabled;

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         enabled <= `THERMAL_EN_RESET;
      else if (apply)
         enabled <= next_enabled;
   end

endmodule : thermal_setting

// *** hw/inventory_pack.sv ***
// packs the product and serial number records into response words
// assumes lengths never exceed the text width; text byte 0 goes first
`timescale 1ns/1ps
`include "thermal_inv_defines.svh"

module inventory_pack
   import thermal_inv_pkg::*;
(
   // record contents
   input  thermal_inv_pkg::inv_text_t                  product,
   input  wire logic [4:0]                             product_len,
   input  thermal_inv_pkg::inv_text_t                  serial,
   input  wire logic [4:0]                             serial_len,
   // packed words from byte 20 onward
   output logic [`INV_WORDS-1:0][31:0]                 words,
   output logic [3:0]                                  nwords
);

   logic [5:0] total;

   // count, two headers of two bytes each, then the text
   assign total  = 6'd5 + {1'b0, product_len} + {1'b0, serial_len};
   assign nwords = 4'((total + 6'd3) >> 2);

   genvar p;
   generate
      for (p = 0; p < `INV_BYTES; p = p + 1)
      begin : g_byte
         logic [5:0] pos;
         logic [5:0] off_pn;
         logic [5:0] off_sn;
         logic [5:0] sn_hdr;
         logic [7:0] b;
         assign pos    = 6'(p);
         assign off_pn = pos - 6'd3;
         assign sn_hdr = 6'd3 + {1'b0, product_len};
         assign off_sn = pos - sn_hdr - 6'd2;
         // length byte sits above the type byte in each header
         assign b = (pos == 6'd0)                                  ? `INV_NUM_RECORDS :
                    (pos == 6'd1)                                  ? {3'h0, product_len} :
                    (pos == 6'd2)                                  ? `INV_TYPE_PRODUCT :
                    (pos < sn_hdr)                                 ? product[off_pn[3:0]] :
                    (pos == sn_hdr)                                ? {3'h0, serial_len} :
                    (pos == sn_hdr + 6'd1)                         ? `INV_TYPE_SERIAL :
                    (pos < sn_hdr + 6'd2 + {1'b0, serial_len})     ? serial[off_sn[3:0]] :
                                                                     8'h00;
         // ascii text with no terminator; trailing bytes pad with zero
         assign words[p / 4][31 - 8 * (p % 4) -: 8] = b;
      end
   endgenerate

endmodule : inventory_pack

// *** hw/thermal_inv_cmds.sv ***
// package-level handler for thermal shutdown control, inventory and transceiver temperature
// assumes header, checksum and identifier checks are done outside; hdr_ok reports them
// response words start at byte 16 and stop before the checksum
// Summary of operation
// - opcode 0x4b selects thermal shutdown control
// - capability bit 7 advertises thermal self-shutdown
// - action 0 disable, 1 enable, 2 query
// - control response opcode is 0xcb
// - always answer unless checksum or identifier fails
// - operating state shows setting after action
// - locked setting refuses enable/disable, invalid parameter
// - untouched fields report their present values
// - shutdown temperature in low byte, bytes 20-23
// - status bit 0 is enablement
// - status bit 1 is configurable, others zero
// - opcode 0x4e is the package inventory query
// - inventory always answered with opcode 0xce
// - inventory text is unterminated ascii
// - record count then records from byte 20
// - header low byte is the attribute type
// - header bits 15..8 hold value length
// - inventory uses no query-specific reason code
// - transceiver thresholds at 20-23, temperature 24-25
// - transceiver values forwarded whole and unmodified
// - no transceiver data gives information-not-available
`timescale 1ns/1ps
`include "thermal_inv_defines.svh"

module thermal_inv_cmds
   import thermal_inv_pkg::*;
(
   // clock and reset
   input  wire logic                     clk,
   input  wire logic                     reset_n,
   // request from the packet receiver
   input  wire logic                     req_valid,
   output logic                          req_ready,
   input  thermal_inv_pkg::req_t         req,
   input  wire logic                     hdr_ok,
   output logic                          req_unhandled,
   // response words toward the packet transmitter
   output logic                          resp_valid,
   input  wire logic                     resp_ready,
   output thermal_inv_pkg::resp_t        resp,
   // thermal self-shutdown
   input  wire logic                     cfg_locked,
   input  wire logic [7:0]               shutdown_temp,
   output logic                          shutdown_enable,
   output logic [7:0]                    cap_flags,
   // inventory contents
   input  thermal_inv_pkg::inv_text_t    product,
   input  wire logic [4:0]               product_len,
   input  thermal_inv_pkg::inv_text_t    serial,
   input  wire logic [4:0]               serial_len,
   // transceiver readings
   input  thermal_inv_pkg::xcvr_t        xcvr
);

   import thermal_inv_pkg::*;

   logic                          rst_meta;
   logic                          rst_n;
   state_t                        state;
   state_t                        next_state;
   logic [`RESP_WORDS-1:0][31:0]  words;
   logic [`RESP_WORDS-1:0][31:0]  next_words;
   logic [3:0]                    count;
   logic [3:0]                    next_count;
   logic [7:0]                    rsp_opcode;
   logic [7:0]                    next_rsp_opcode;
   logic                          unhandled;

   logic                          take;
   logic                          is_thermal;
   logic                          is_inventory;
   logic                          is_xcvr;
   logic                          known;
   logic                          pop;
   logic [7:0]                    action;

   logic                          thermal_en;
   logic                          thermal_next_en;
   logic                          thermal_fail;
   logic [7:0]                    status_byte;
   logic [`INV_WORDS-1:0][31:0]   inv_words;
   logic [3:0]                    inv_nwords;
   logic                          xcvr_avail;

   // reset released through two stages; only the second is used
   always_ff @(posedge clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rst_meta <= 1'b0;
         rst_n    <= 1'b0;
      end
      else
      begin
         rst_meta <= 1'b1;
         rst_n    <= rst_meta;
      end
   end

   // request decode
   assign req_ready    = (state == ST_IDLE);
   assign take         = req_valid && req_ready && hdr_ok;
   assign is_thermal   = (req.opcode == `OPC_THERMAL_CTL);
   assign is_inventory = (req.opcode == `OPC_INVENTORY);
   assign is_xcvr      = (req.opcode == `OPC_XCVR_TEMP);
   assign known        = is_thermal || is_inventory || is_xcvr;
   // upper action bytes are reserved and not looked at
   assign action       = req.action_word[7:0];
   assign pop          = resp_valid && resp_ready;

   // the package channel is the manager's duty; the decode does not rely on it
   thermal_setting u_setting
   (
      .clk          (clk),
      .rst_n        (rst_n),
      .apply        (take && is_thermal),
      .action       (action),
      .cfg_locked   (cfg_locked),
      .enabled      (thermal_en),
      .next_enabled (thermal_next_en),
      .fail         (thermal_fail)
   );

   inventory_pack u_inventory
   (
      .product      (product),
      .product_len  (product_len),
      .serial       (serial),
      .serial_len   (serial_len),
      .words        (inv_words),
      .nwords       (inv_nwords)
   );

   assign shutdown_enable = thermal_en;
   // capability byte advertises the feature and nothing else from here
   assign cap_flags       = 8'h01 << `CAP_THERMAL_BIT;

   assign status_byte = {6'h00, !cfg_locked, thermal_next_en};
   assign xcvr_avail  = xcvr.present && xcvr.powered && xcvr.temp_valid;

   // response contents are snapshotted at acceptance so they hold while stalled
   always_comb
   begin
      next_words      = words;
      next_count      = count;
      next_rsp_opcode = rsp_opcode;
      if (take)
      begin
         next_words = '0;
         if (is_thermal)
         begin
            next_rsp_opcode = `OPC_THERMAL_RSP;
            next_words[0]   = thermal_fail ? {`RESP_FAILED, `REASON_INVALID_PARAM}
                                           : {`RESP_COMPLETED, `REASON_NONE};
            // status and temperature are current values even on failure
            next_words[1]   = {16'h0000, status_byte, shutdown_temp};
            next_count      = 4'd2;
         end
         else if (is_inventory)
         begin
            next_rsp_opcode = `OPC_INVENTORY_RSP;
            next_words[0]   = {`RESP_COMPLETED, `REASON_NONE};
            for (int i = 0; i < `INV_WORDS; i++)
            begin
               next_words[i + 1] = inv_words[i];
            end
            next_count      = inv_nwords + 4'd1;
         end
         else if (is_xcvr)
         begin
            next_rsp_opcode = `OPC_XCVR_TEMP_RSP;
            if (xcvr_avail)
            begin
               next_words[0] = {`RESP_COMPLETED, `REASON_NONE};
               // readings are passed through bit for bit
               next_words[1] = {xcvr.high_alarm, xcvr.high_warning};
               next_words[2] = {xcvr.temperature, 16'h0000};
            end
            else
            begin
               next_words[0] = {`RESP_FAILED, `REASON_INFO_NA};
            end
            next_count      = 4'd3;
         end
         else
         begin
            next_count = 4'd0;
         end
      end
      else if (pop)
      begin
         // shift toward the output word so the data port stays a flop
         for (int i = 0; i < `RESP_WORDS - 1; i++)
         begin
            next_words[i] = words[i + 1];
         end
         next_words[`RESP_WORDS - 1] = 32'h0000_0000;
         next_count = count - 4'd1;
      end
   end

   always_comb
   begin
      next_state = state;
      case (state)
         ST_IDLE:
            if (take && known)
               next_state = ST_SEND;
         ST_SEND:
            if (pop && (count == 4'd1))
               next_state = ST_IDLE;
         default:
            next_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state      <= ST_IDLE;
         words      <= '0;
         count      <= 4'd0;
         rsp_opcode <= 8'h00;
         unhandled  <= 1'b0;
      end
      else
      begin
         state      <= next_state;
         words      <= next_words;
         count      <= next_count;
         rsp_opcode <= next_rsp_opcode;
         unhandled  <= take && !known;
      end
   end

   // other opcodes are consumed and flagged for the neighbouring handlers
   assign req_unhandled = unhandled;
   assign resp_valid    = (state == ST_SEND);
   assign resp.opcode   = rsp_opcode;
   assign resp.data     = words[0];
   assign resp.last     = (state == ST_SEND) && (count == 4'd1);

endmodule : thermal_inv_cmds

// *** dv/thermal_inv_cmds_chk.sv ***
// port assertions for the thermal, inventory and transceiver handler
// assumes one clock and reset_n async low; bound below
`timescale 1ns/1ps

module thermal_inv_cmds_chk
   import thermal_inv_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset_n,
   // request and response
   input  wire logic              req_valid,
   input  wire logic              req_ready,
   input  thermal_inv_pkg::req_t  req,
   input  wire logic              hdr_ok,
   input  wire logic              req_unhandled,
   input  wire logic              resp_valid,
   input  wire logic              resp_ready,
   input  thermal_inv_pkg::resp_t resp,
   // thermal setting
   input  wire logic              cfg_locked,
   input  wire logic [7:0]        shutdown_temp,
   input  wire logic              shutdown_enable,
   input  wire logic [7:0]        cap_flags
);
   logic [7:0] last_op;
   wire        take  = req_valid && req_ready && hdr_ok;
   wire        known = req.opcode inside {8'h4b, 8'h4e, 8'h4a};
   wire        thm   = take && req.opcode == 8'h4b;
   wire  [7:0] act   = req.action_word[7:0];

   default clocking @(posedge clk); endclocking
   default disable iff (!reset_n);

   // remembers the taken opcode so every response word can be tied to it
   always_ff @(posedge clk or negedge reset_n)
      if (!reset_n)
         last_op <= 8'h00;
      else if (take)
         last_op <= req.opcode;

   property p_cap; cap_flags == 8'h80; endproperty
   a_cap: assert property (p_cap) else $error("capability bit wrong");
   property p_ans; take && known |=> resp_valid && !req_ready; endproperty
   a_ans: assert property (p_ans) else $error("request not answered");
   property p_nohdr; req_valid && req_ready && !hdr_ok |=> req_ready && !resp_valid; endproperty
   a_nohdr: assert property (p_nohdr) else $error("bad header answered");
   property p_unh; take && !known |=> req_unhandled && !resp_valid ##1 !req_unhandled; endproperty
   a_unh: assert property (p_unh) else $error("unknown opcode handling");
   property p_opc; resp_valid |-> resp.opcode == (last_op | 8'h80); endproperty
   a_opc: assert property (p_opc) else $error("response opcode wrong");
   property p_stand; resp_valid && !resp_ready |=> resp_valid && $stable(resp); endproperty
   a_stand: assert property (p_stand) else $error("word changed while stalled");
   property p_en; thm && !cfg_locked && act < 8'h02 |=> shutdown_enable == $past(act[0]); endproperty
   a_en: assert property (p_en) else $error("setting not applied");
   property p_lock; thm && (cfg_locked || act > 8'h01) |=> $stable(shutdown_enable); endproperty
   a_lock: assert property (p_lock) else $error("setting changed");
   property p_fail; thm && (act > 8'h02 || (cfg_locked && act < 8'h02)) |=> resp.data == 32'h00010002; endproperty
   a_fail: assert property (p_fail) else $error("failure code wrong");
   property p_stat; resp_valid && resp.opcode == 8'hcb && resp.last |-> resp.data == {16'h0, 6'h0, !cfg_locked, shutdown_enable, shutdown_temp}; endproperty
   a_stat: assert property (p_stat) else $error("status word wrong");
   property p_pop; resp_valid && resp_ready && resp.last |=> !resp_valid && req_ready; endproperty
   a_pop: assert property (p_pop) else $error("no return to idle");
endmodule : thermal_inv_cmds_chk

bind thermal_inv_cmds thermal_inv_cmds_chk chk (.clk, .reset_n, .req_valid, .req_ready, .req,
   .hdr_ok, .req_unhandled, .resp_valid, .resp_ready, .resp, .cfg_locked, .shutdown_temp,
   .shutdown_enable, .cap_flags);

// *** dv/mgmt_model.sv ***
// management side model: issues requests and collects response words
// assumes valid/ready handshakes on both groups and a 20 ns clock
`timescale 1ns/1ps

module mgmt_model
   import thermal_inv_pkg::*;
(
   // clock
   input  wire logic              clk,
   // request side
   input  wire logic              req_ready,
   output thermal_inv_pkg::req_t  req,
   output logic                   req_valid,
   output logic                   hdr_ok,
   // response side
   input  wire logic              resp_valid,
   input  thermal_inv_pkg::resp_t resp,
   output logic                   resp_ready
);
   logic [31:0] w [16];
   logic [7:0]  op = 8'h00;
   logic        done = 1'b0;
   logic        slow = 1'b0;
   logic [1:0]  cyc = 2'd0;
   int          n = 0;

   initial
   begin
      req = '0;
      req_valid = 1'b0;
      hdr_ok = 1'b0;
      resp_ready = 1'b0;
   end

   always @(posedge clk)
   begin
      if (resp_valid && resp_ready)
      begin
         w[n] = resp.data;
         op = resp.opcode;
         n = n + 1;
         done = resp.last;
      end
      cyc = cyc + 2'd1;
      // slow mode stalls three cycles in four
      #1 resp_ready = !slow || cyc == 2'd0;
   end

   task automatic send(input logic [7:0] o, input logic [7:0] a, input logic ok);
      @(posedge clk);
      #1 n = 0;
      done = 1'b0;
      req_valid = 1'b1;
      hdr_ok = ok;
      req = '{o, 5'h1f, {24'h0, a}};
      do @(posedge clk); while (req_ready !== 1'b1);
      #1 req_valid = 1'b0;
      // released lines must not keep showing the old request
      req = ~req;
      hdr_ok = !ok;
   endtask : send

   task automatic fin();
      int k;
      k = 0;
      while (!done && k < 60)
      begin
         @(posedge clk);
         k = k + 1;
      end
   endtask : fin
endmodule : mgmt_model

// *** dv/thermal_inv_cmds_tb.sv ***
// self-checking bench for the thermal, inventory and transceiver handler
// assumes mgmt_model on both handshakes and the checker bound by its own file
`timescale 1ns/1ps

module thermal_inv_cmds_tb;
   import thermal_inv_pkg::*;

   logic                       clk = 1'b0;
   logic                       reset_n = 1'b0;
   logic                       req_valid;
   logic                       req_ready;
   thermal_inv_pkg::req_t      req;
   logic                       hdr_ok;
   logic                       req_unhandled;
   logic                       resp_valid;
   logic                       resp_ready;
   thermal_inv_pkg::resp_t     resp;
   logic                       cfg_locked = 1'b0;
   logic [7:0]                 shutdown_temp = 8'h5a;
   logic                       shutdown_enable;
   logic [7:0]                 cap_flags;
   thermal_inv_pkg::inv_text_t product;
   thermal_inv_pkg::inv_text_t serial;
   logic [4:0]                 product_len = 5'd3;
   logic [4:0]                 serial_len = 5'd2;
   thermal_inv_pkg::xcvr_t     xcvr = '{1'b1, 1'b1, 1'b1, 16'h1234, 16'h5678, 16'h9abc};
   int                         n_fail = 0;
   int                         comparisons = 0;
   int                         cycles = 0;

   thermal_inv_cmds dut (.clk, .reset_n, .req_valid, .req_ready, .req, .hdr_ok, .req_unhandled,
      .resp_valid, .resp_ready, .resp, .cfg_locked, .shutdown_temp, .shutdown_enable, .cap_flags,
      .product, .product_len, .serial, .serial_len, .xcvr);

   mgmt_model mc (.clk, .req_ready, .req, .req_valid, .hdr_ok, .resp_valid, .resp, .resp_ready);

   initial
   begin
      forever #10 clk = ~clk;
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         n_fail++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check

   task automatic results();
      $display("comparisons %0d mismatches %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : results

   task automatic thm(input logic [7:0] a, input logic [31:0] w0, input logic [7:0] st);
      mc.send(8'h4b, a, 1'b1);
      mc.fin();
      check(mc.n, 2);
      check(mc.op, 8'hcb);
      check(mc.w[0], w0);
      check(mc.w[1], {16'h0, st, 8'h5a});
      check(shutdown_enable, st[0]);
   endtask : thm

   task automatic xc(input logic [31:0] w0, input logic [31:0] w1, input logic [31:0] w2);
      mc.send(8'h4a, 8'h00, 1'b1);
      mc.fin();
      check(mc.n, 3);
      check(mc.op, 8'hca);
      check(mc.w[0], w0);
      check(mc.w[1], w1);
      check(mc.w[2], w2);
   endtask : xc

   // a hang counts as a mismatch and ends in the normal report
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         n_fail++;
         results();
      end
   end

   initial
   begin
      // filler beyond each length must never reach the response
      product = {16{8'h7e}};
      product[2:0] = {8'h31, 8'h42, 8'h41};
      serial = {16{8'h7e}};
      serial[1:0] = {8'h39, 8'h5a};
      repeat (16) @(posedge clk);
      #1 reset_n = 1'b1;
      repeat (3) @(posedge clk);
      check(cap_flags, 8'h80);
      check(shutdown_enable, 1'b1);
      thm(8'h02, 32'h0, 8'h03);
      thm(8'h00, 32'h0, 8'h02);
      mc.slow = 1'b1;
      thm(8'h01, 32'h0, 8'h03);
      mc.slow = 1'b0;
      thm(8'h03, 32'h00010002, 8'h03);
      thm(8'hff, 32'h00010002, 8'h03);
      #1 cfg_locked = 1'b1;
      thm(8'h00, 32'h00010002, 8'h01);
      thm(8'h01, 32'h00010002, 8'h01);
      thm(8'h02, 32'h0, 8'h01);
      #1 cfg_locked = 1'b0;
      mc.send(8'h4b, 8'h00, 1'b0);
      repeat (4) @(posedge clk);
      check(mc.n, 0);
      check(shutdown_enable, 1'b1);
      mc.send(8'h55, 8'h00, 1'b1);
      // the flag stands for one cycle only, right after the accepting edge
      check(req_unhandled, 1'b1);
      @(posedge clk);
      #1 check(req_unhandled, 1'b0);
      repeat (3) @(posedge clk);
      check(mc.n, 0);
      mc.slow = 1'b1;
      mc.send(8'h4e, 8'h00, 1'b1);
      mc.fin();
      mc.slow = 1'b0;
      check(mc.n, 4);
      check(mc.op, 8'hce);
      check(mc.w[0], 32'h0);
      check(mc.w[1], 32'h02030041);
      check(mc.w[2], 32'h42310201);
      check(mc.w[3], 32'h5a390000);
      xc(32'h0, 32'h12345678, 32'h9abc0000);
      for (int i = 0; i < 3; i++)
      begin
         #1 {xcvr.present, xcvr.powered, xcvr.temp_valid} = ~(3'b001 << i);
         xc(32'h00010008, 32'h0, 32'h0);
      end
      results();
   end
endmodule : thermal_inv_cmds_tb
